// ==== rtl/cpu_subset_map.svh ====
// constants of the instruction subset executor: bus map, fields, opcodes
// assumes a 12-bit AXI4-Lite byte address and 16-bit instruction words
// Notes on behaviour
// - clear accumulator: zero it, set null flag
// - dest bit 0 to accumulator, 1 to file
// - or-immediate takes 8-bit value from word
// - or-immediate ORs into accumulator, updates null flag
// - decrement-skip subtracts one, flags untouched
// - zero decrement result: idle slot, two cycles
// - increment-skip adds one, flags untouched, skips on zero
// - increment register adds one, updates null flag
// - jump loads 11 bits, top from latch 4:3
// - jump takes two cycles, no flags touched
`ifndef CPU_SUBSET_MAP_SVH
`define CPU_SUBSET_MAP_SVH
// register byte offsets
`define OFS_INSTR 12'h000
`define OFS_ACC 12'h004
`define OFS_STATUS 12'h008
`define OFS_PC 12'h00C
`define OFS_UTL 12'h010
`define OFS_CYCLES 12'h014
// file register window 0x200..0x3FC, one register per word
`define WIN_TAG_MSB 11
`define WIN_TAG_LSB 9
`define WIN_TAG 3'h1
`define WIN_IDX_MSB 8
`define WIN_IDX_LSB 2
// instruction word fields
`define OPC_MSB 15
`define OPC_LSB 12
`define DEST_BIT 7
`define FADR_MSB 6
`define K8_MSB 7
`define K11_MSB 10
`define UTL_SEL_MSB 4
`define UTL_SEL_LSB 3
// opcodes
`define OPC_IDLE 4'h0
`define OPC_CLRACC 4'h1
`define OPC_DECSKIP 4'h2
`define OPC_INCSKIP 4'h3
`define OPC_JUMP 4'h4
`define OPC_ORIMM 4'h5
`define OPC_INCREG 4'h6
// status register bits
`define ST_NULL_BIT 0
`define ST_BUSY_BIT 1
`define ST_SKIP_BIT 2
// reset values
`define RST_ACC 8'h00
`define RST_PC 13'h0000
`define RST_UTL 7'h00
`define RST_INSTR 16'h0000
`define RST_NULL 1'b0
// bus responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// ==== rtl/cpu_subset_pkg.sv ====
// types shared by the instruction subset executor
// assumes the map header sits beside it on the include path
package cpu_subset_pkg;
  `include "cpu_subset_map.svh"

  typedef logic [7:0] byte_t;
  typedef logic [12:0] pc_t;

  // execution sequence of one instruction
  typedef enum logic [1:0] {
    EX_IDLE = 2'b00,
    EX_FETCH = 2'b01,
    EX_EXEC = 2'b10,
    EX_SLOT = 2'b11
  } exec_state_t;

  // instruction kinds
  typedef enum logic [3:0] {
    OP_IDLE = `OPC_IDLE,
    OP_CLRACC = `OPC_CLRACC,
    OP_DECSKIP = `OPC_DECSKIP,
    OP_INCSKIP = `OPC_INCSKIP,
    OP_JUMP = `OPC_JUMP,
    OP_ORIMM = `OPC_ORIMM,
    OP_INCREG = `OPC_INCREG
  } opcode_t;

  // bus register selection
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_INSTR = 3'h1,
    SEL_ACC = 3'h2,
    SEL_STATUS = 3'h3,
    SEL_PC = 3'h4,
    SEL_UTL = 3'h5,
    SEL_CYCLES = 3'h6,
    SEL_FILE = 3'h7
  } reg_sel_t;
endpackage

// ==== rtl/file_reg_ram.sv ====
// file register storage, 128 bytes, one port
// assumes the caller never reads and writes through it in one cycle by intent
`timescale 1ns/1ns
module file_reg_ram (
  input wire logic sys_clk_i,
  input wire logic we_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_q [0:127]; // contents, not reset: data only

  // write port; read data come out of a register, old value on collision
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_o <= mem_q[addr_i];
  end
endmodule

// ==== rtl/cpu_subset_exec.sv ====
// executor for a subset of an 8-bit core's instructions behind AXI4-Lite
// assumes one clock, synchronous active-low reset, a well-behaved master
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module cpu_subset_exec (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output cpu_subset_pkg::byte_t acc_o,
  output logic null_flag_o,
  output cpu_subset_pkg::pc_t pc_o,
  output logic busy_o
);
  import cpu_subset_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // byte address to register selection
  function automatic reg_sel_t decode(input logic [11:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a[`WIN_TAG_MSB:`WIN_TAG_LSB] == `WIN_TAG) begin
      s = SEL_FILE;
    end else begin
      unique case (a)
        `OFS_INSTR: s = SEL_INSTR;
        `OFS_ACC: s = SEL_ACC;
        `OFS_STATUS: s = SEL_STATUS;
        `OFS_PC: s = SEL_PC;
        `OFS_UTL: s = SEL_UTL;
        `OFS_CYCLES: s = SEL_CYCLES;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  exec_state_t ex_state_q; // instruction sequence
  exec_state_t ex_state_d;
  logic [15:0] instr_q; // instruction under way or last run
  byte_t acc_q; // accumulator
  logic null_q; // result null flag
  pc_t pc_q; // program counter
  logic [6:0] utl_q; // upper target latch
  logic skip_q; // last instruction skipped the next word; a jump's slot leaves it clear
  logic [31:0] cycles_q; // instruction cycles spent
  logic busy_q; // registered busy
  logic [11:0] aw_addr_q; // captured write address
  logic aw_got_q;
  logic aw_got_d;
  logic [31:0] w_data_q; // captured write data
  logic [3:0] w_strb_q;
  logic w_got_q;
  logic w_got_d;
  logic [11:0] ar_addr_q; // captured read address
  logic ar_got_q;
  logic ar_got_d;
  logic rd_wait_q; // file window read in flight
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic awready_q;
  logic wready_q;
  logic arready_q;

  // memory port
  logic mem_we;
  logic [6:0] mem_addr;
  byte_t mem_wdata;
  byte_t mem_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // decode of the instruction under way

  opcode_t op;
  logic dest_file; // result goes back to the file register
  logic [6:0] f_addr;
  byte_t imm8;
  logic [10:0] imm11;
  logic file_op;
  byte_t result;
  logic res_null;
  logic take_slot;
  logic wr_commit;
  logic rd_commit;
  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  logic [31:0] wr_word;
  logic [31:0] pc_wr_word; // bus write merged into the program counter word

  assign op = opcode_t'(instr_q[`OPC_MSB:`OPC_LSB]);
  assign dest_file = instr_q[`DEST_BIT];
  assign f_addr = instr_q[`FADR_MSB:0];
  assign imm8 = instr_q[`K8_MSB:0];
  assign imm11 = instr_q[`K11_MSB:0];
  assign file_op = (op == OP_DECSKIP) || (op == OP_INCSKIP) || (op == OP_INCREG);

  // result of the arithmetic; 8-bit sums wrap by width
  always_comb begin
    result = 8'h00;
    unique case (op)
      OP_DECSKIP: result = mem_rdata - 8'h01;
      OP_INCSKIP, OP_INCREG: result = mem_rdata + 8'h01;
      OP_ORIMM: result = acc_q | imm8;
      default: result = 8'h00;
    endcase
  end

  assign res_null = (result == 8'h00);
  // an idle slot follows a jump or a skip on a null result
  assign take_slot = (op == OP_JUMP) ||
                     (((op == OP_DECSKIP) || (op == OP_INCSKIP)) && res_null);

  ////////////////////////////////////////////////////////////////////////////
  // bus commit points; the executor owns the memory while busy

  assign wr_sel = decode(aw_addr_q);
  assign rd_sel = decode(ar_addr_q);
  assign wr_commit = aw_got_q && w_got_q && !bvalid_q && (ex_state_q == EX_IDLE);
  // a write wins a same-cycle clash; the read retries next cycle
  assign rd_commit = ar_got_q && !rvalid_q && !rd_wait_q && !wr_commit && (ex_state_q == EX_IDLE);
  assign aw_got_d = aw_got_q ? !wr_commit : (s_axi_awvalid && awready_q);
  assign w_got_d = w_got_q ? !wr_commit : (s_axi_wvalid && wready_q);
  assign ar_got_d = ar_got_q ? !rd_commit : (s_axi_arvalid && arready_q);

  // memory port mux
  always_comb begin
    mem_we = 1'b0;
    mem_addr = f_addr;
    mem_wdata = result;
    if (ex_state_q == EX_EXEC) begin
      mem_we = file_op && dest_file;
    end else if (wr_commit && (wr_sel == SEL_FILE)) begin
      mem_we = w_strb_q[0];
      mem_addr = aw_addr_q[`WIN_IDX_MSB:`WIN_IDX_LSB];
      mem_wdata = w_data_q[7:0];
    end else if (rd_commit) begin
      mem_addr = ar_addr_q[`WIN_IDX_MSB:`WIN_IDX_LSB];
    end
  end

  file_reg_ram u_file (
    .sys_clk_i(sys_clk_i),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // execution sequence

  // fetch reads the operand, exec retires, slot replaces the next instruction
  always_comb begin
    ex_state_d = ex_state_q;
    unique case (ex_state_q)
      EX_IDLE: begin
        if (wr_commit && (wr_sel == SEL_INSTR)) begin
          ex_state_d = EX_FETCH;
        end
      end
      EX_FETCH: ex_state_d = EX_EXEC;
      EX_EXEC: ex_state_d = take_slot ? EX_SLOT : EX_IDLE;
      EX_SLOT: ex_state_d = EX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ex_state_q <= EX_IDLE;
      busy_q <= 1'b0;
    end else begin
      ex_state_q <= ex_state_d;
      busy_q <= (ex_state_d != EX_IDLE);
    end
  end

  // instruction register: a write starts execution
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      instr_q <= `RST_INSTR;
    end else if (wr_commit && (wr_sel == SEL_INSTR)) begin
      instr_q <= wr_word[15:0];
    end
  end

  assign wr_word = merge(32'h00000000, w_data_q, w_strb_q);
  // only the low 13 bits exist; upper lanes of the bus word are dropped on purpose
  assign pc_wr_word = merge({19'h00000, pc_q}, w_data_q, w_strb_q);

  // accumulator: clear, or-immediate, or file result with dest 0
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      acc_q <= `RST_ACC;
    end else if (ex_state_q == EX_EXEC) begin
      if (op == OP_CLRACC) begin
        acc_q <= 8'h00;
      end else if (op == OP_ORIMM) begin
        acc_q <= result;
      end else if (file_op && !dest_file) begin
        acc_q <= result;
      end
    end else if (wr_commit && (wr_sel == SEL_ACC)) begin
      // only byte lane 0 carries the accumulator
      acc_q <= w_strb_q[0] ? w_data_q[7:0] : acc_q;
    end
  end

  // null flag: skips and jumps leave it alone
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      null_q <= `RST_NULL;
    end else if (ex_state_q == EX_EXEC) begin
      if (op == OP_CLRACC) begin
        null_q <= 1'b1;
      end else if ((op == OP_ORIMM) || (op == OP_INCREG)) begin
        null_q <= res_null;
      end
    end else if (wr_commit && (wr_sel == SEL_STATUS) && w_strb_q[0]) begin
      null_q <= w_data_q[`ST_NULL_BIT];
    end
  end

  // program counter: advance, load on jump, step past the skipped word
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      pc_q <= `RST_PC;
    end else if (ex_state_q == EX_EXEC) begin
      if (op == OP_JUMP) begin
        pc_q <= {utl_q[`UTL_SEL_MSB:`UTL_SEL_LSB], imm11};
      end else begin
        pc_q <= pc_q + 13'h0001;
      end
    end else if ((ex_state_q == EX_SLOT) && skip_q) begin
      pc_q <= pc_q + 13'h0001;
    end else if (wr_commit && (wr_sel == SEL_PC)) begin
      pc_q <= pc_wr_word[12:0];
    end
  end

  // upper target latch, software owned
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      utl_q <= `RST_UTL;
    end else if (wr_commit && (wr_sel == SEL_UTL) && w_strb_q[0]) begin
      utl_q <= w_data_q[6:0];
    end
  end

  // skip marker and cycle count; a slot costs a cycle like any other
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      skip_q <= 1'b0;
      cycles_q <= 32'h00000000;
    end else begin
      if (ex_state_q == EX_EXEC) begin
        skip_q <= take_slot && (op != OP_JUMP);
      end
      if ((ex_state_q == EX_EXEC) || (ex_state_q == EX_SLOT)) begin
        cycles_q <= cycles_q + 32'h00000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels

  // ready drops once an item is held, so address and data may come in any order
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awready_q <= !aw_got_d;
      wready_q <= !w_got_d;
      if (s_axi_awvalid && awready_q) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // write response
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else if (wr_commit) begin
      bvalid_q <= 1'b1;
      bresp_q <= ((wr_sel == SEL_NONE) || (wr_sel == SEL_CYCLES)) ? `RESP_DECERR : `RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channels

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ar_got_q <= 1'b0;
      arready_q <= 1'b0;
      ar_addr_q <= 12'h000;
    end else begin
      ar_got_q <= ar_got_d;
      arready_q <= !ar_got_d;
      if (s_axi_arvalid && arready_q) begin
        ar_addr_q <= s_axi_araddr;
      end
    end
  end

  // register reads answer at once; the window waits one cycle for the memory
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rvalid_q <= 1'b0;
      rresp_q <= `RESP_OKAY;
      rdata_q <= 32'h00000000;
      rd_wait_q <= 1'b0;
    end else if (rd_wait_q) begin
      rd_wait_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= `RESP_OKAY;
      rdata_q <= {24'h000000, mem_rdata};
    end else if (rd_commit) begin
      rd_wait_q <= (rd_sel == SEL_FILE);
      rvalid_q <= (rd_sel != SEL_FILE);
      rresp_q <= (rd_sel == SEL_NONE) ? `RESP_DECERR : `RESP_OKAY;
      unique case (rd_sel)
        SEL_INSTR: rdata_q <= {16'h0000, instr_q};
        SEL_ACC: rdata_q <= {24'h000000, acc_q};
        SEL_STATUS: rdata_q <= {29'h00000000, skip_q, busy_q, null_q};
        SEL_PC: rdata_q <= {19'h00000, pc_q};
        SEL_UTL: rdata_q <= {25'h0000000, utl_q};
        SEL_CYCLES: rdata_q <= cycles_q;
        SEL_FILE, SEL_NONE: rdata_q <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign acc_o = acc_q;
  assign null_flag_o = null_q;
  assign pc_o = pc_q;
  assign busy_o = busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  logic in_exec;
  assign in_exec = (ex_state_q == EX_EXEC);

  sequence slot_then_idle;
    (ex_state_q == EX_SLOT) ##1 (ex_state_q == EX_IDLE);
  endsequence

  sequence skip_taken(opcode_t o);
    in_exec && (op == o) && res_null;
  endsequence

  a_clear_acc: assert property (in_exec && (op == OP_CLRACC) |=> (acc_q == 8'h00) && null_q)
    else $error("clear did not zero accumulator and set flag");
  a_dest_select: assert property (in_exec && file_op |-> (mem_we == dest_file) && (mem_addr == f_addr))
    else $error("result routed to wrong destination");
  a_dest_keep_acc: assert property (in_exec && file_op && dest_file |=> $stable(acc_q))
    else $error("file destination disturbed accumulator");
  a_or_result: assert property (in_exec && (op == OP_ORIMM) |=>
                                (acc_q == ($past(acc_q) | $past(imm8))) && (null_q == (acc_q == 8'h00)))
    else $error("or-immediate result or flag wrong");
  a_dec_flags: assert property (in_exec && (op == OP_DECSKIP) |=> $stable(null_q))
    else $error("decrement-skip changed the flag");
  a_dec_skip: assert property (skip_taken(OP_DECSKIP) |=> slot_then_idle)
    else $error("decrement-skip did not insert idle slot");
  a_dec_noskip: assert property (in_exec && (op == OP_DECSKIP) && !res_null |=> ex_state_q == EX_IDLE)
    else $error("decrement-skip skipped on nonzero");
  a_inc_skip: assert property (skip_taken(OP_INCSKIP) |=> ##1 (pc_q == $past(pc_q, 2) + 13'h0002))
    else $error("increment-skip did not step past next word");
  a_inc_flag: assert property (in_exec && (op == OP_INCREG) |=> null_q == ($past(mem_rdata) == 8'hFF))
    else $error("increment flag wrong");
  a_jump_load: assert property (in_exec && (op == OP_JUMP) |=>
                                (pc_q == {$past(utl_q[4:3]), $past(imm11)}) && $stable(null_q))
    else $error("jump target or flags wrong");
  a_jump_slot: assert property (in_exec && (op == OP_JUMP) |=> slot_then_idle and ##1 $stable(pc_q))
    else $error("jump did not take two cycles");
  a_dec_wrap: assert property (in_exec && (op == OP_DECSKIP) && (mem_rdata == 8'h00) |-> result == 8'hFF)
    else $error("decrement did not wrap");
endmodule

// ==== test/tb.sv ====
// self-checking bench for the instruction subset executor, driven over AXI4-Lite
// assumes the package and the map header are compiled first; the design carries its own assertions
`timescale 1ns/1ns
`include "cpu_subset_map.svh"
module tb;
  import cpu_subset_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // clock, reset and bus signals
  logic sys_clk_i = 1'b0; // 250 MHz core clock
  logic reset_n_i = 1'b0; // synchronous, active low
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF; // full words only
  logic awready, wready, bvalid, arready, rvalid, busy_o, null_flag_o;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [1:0] r;
  byte_t acc_o;
  pc_t pc_o;
  int err_count = 0; // mismatches seen
  int n_compared = 0; // comparisons made
  // or-immediate cases: accumulator before, immediate, result
  byte_t or_pre [4] = '{8'h00, 8'h3C, 8'h00, 8'hA5};
  byte_t or_imm [4] = '{8'h00, 8'h81, 8'hFF, 8'h5A};
  byte_t or_res [4] = '{8'h00, 8'hBD, 8'hFF, 8'hFF};
  // jump cases: latch, 11-bit target, expected counter
  logic [6:0] j_utl [2] = '{7'h18, 7'h0F};
  logic [10:0] j_imm [2] = '{11'h7FF, 11'h123};
  pc_t j_pc [2] = '{13'h1FFF, 13'h0923};

  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  cpu_subset_exec dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .acc_o(acc_o), .null_flag_o(null_flag_o), .pc_o(pc_o), .busy_o(busy_o));

  ////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // bus master: address and data offered together, each released when taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
    int n;
    logic aw_done, w_done, got;
    aw_done = 1'b0;
    w_done = 1'b0;
    got = 1'b0;
    n = 0;
    @(posedge sys_clk_i);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got && n < 400) begin
      @(posedge sys_clk_i);
      n++;
      if (aw_done && w_done && bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        got = 1'b1;
      end
      if (awvalid === 1'b1 && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid === 1'b1 && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    if (!got) check(1'b0, 1'b1, "write answer");
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    logic ar_done, got;
    ar_done = 1'b0;
    got = 1'b0;
    n = 0;
    @(posedge sys_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got && n < 400) begin
      @(posedge sys_clk_i);
      n++;
      if (ar_done && rvalid === 1'b1) begin
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        got = 1'b1;
      end
      if (arvalid === 1'b1 && arready === 1'b1) begin
        ar_done = 1'b1;
        arvalid <= 1'b0;
      end
    end
    if (!got) check(1'b0, 1'b1, "read answer");
  endtask

  // byte address of file register f in the window
  function automatic logic [11:0] fa(input logic [6:0] f);
    return {3'h1, f, 2'b00};
  endfunction

  // run one instruction; compares the cycle count step and, if asked, the counter step
  task automatic do_instr(input logic [15:0] w, input int ncyc, input bit chk_pc);
    logic [31:0] c0, c1;
    logic [1:0] rs;
    pc_t p0;
    int n;
    axi_read(`OFS_CYCLES, c0, rs);
    #1 p0 = pc_o;
    axi_write(`OFS_INSTR, {16'h0000, w}, rs);
    n = 0;
    #1;
    check(busy_o, 1'b1, "busy");
    while (busy_o !== 1'b0 && n < 50) begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    axi_read(`OFS_CYCLES, c1, rs);
    #1 check(c1 - c0, ncyc, "cycles");
    if (chk_pc) check(pc_o, pc_t'(p0 + 13'(ncyc)), "pc step");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1 check(acc_o, 8'h00, "acc reset");
    check(pc_o, 13'h0000, "pc reset");
    check(null_flag_o, 1'b0, "flag reset");
    axi_read(12'h020, d, r);
    check(r, `RESP_DECERR, "unmapped resp");
    check(d, 32'h0, "unmapped data");
    axi_write(`OFS_CYCLES, 32'h55, r);
    check(r, `RESP_DECERR, "ro write");
    // clear accumulator from a non-zero value with the flag low
    axi_write(`OFS_ACC, 32'h5A, r);
    do_instr(16'h1000, 1, 1);
    check(acc_o, 8'h00, "clear acc");
    check(null_flag_o, 1'b1, "clear flag");
    // or-immediate; the flag is preset opposite to the expected value
    for (int i = 0; i < 4; i++) begin
      axi_write(`OFS_ACC, {24'h0, or_pre[i]}, r);
      axi_write(`OFS_STATUS, {31'h0, or_res[i] != 8'h00}, r);
      do_instr({8'h50, or_imm[i]}, 1, 1);
      check(acc_o, or_res[i], "or acc");
      check(null_flag_o, or_res[i] == 8'h00, "or flag");
    end
    // increment register: wrap to zero into acc, then into the file
    axi_write(fa(5), 32'hFF, r);
    axi_write(`OFS_STATUS, 32'h0, r);
    do_instr(16'h6005, 1, 1);
    check(acc_o, 8'h00, "inc to acc");
    check(null_flag_o, 1'b1, "inc flag");
    axi_read(fa(5), d, r);
    check(d, 32'hFF, "file kept");
    axi_write(`OFS_ACC, 32'h33, r);
    do_instr(16'h6085, 1, 1);
    axi_read(fa(5), d, r);
    check(d, 32'h00, "inc to file");
    check(acc_o, 8'h33, "acc kept");
    axi_write(fa(7), 32'h41, r);
    do_instr(16'h6087, 1, 1);
    axi_read(fa(7), d, r);
    check(d, 32'h42, "inc value");
    check(null_flag_o, 1'b0, "inc flag clr");
    // decrement-skip: zero result skips and leaves a low flag low
    axi_write(fa(9), 32'h01, r);
    do_instr(16'h2089, 2, 1);
    axi_read(fa(9), d, r);
    check(d, 32'h00, "dec file");
    check(null_flag_o, 1'b0, "dec flag");
    axi_read(`OFS_STATUS, d, r);
    check(d, 32'h4, "status skip");
    axi_write(`OFS_STATUS, 32'h1, r);
    do_instr(16'h2009, 1, 1);
    check(acc_o, 8'hFF, "dec wrap");
    check(null_flag_o, 1'b1, "dec flag kept");
    // increment-skip: wrap to zero skips, otherwise one cycle
    axi_write(`OFS_STATUS, 32'h0, r);
    axi_write(fa(10), 32'hFF, r);
    do_instr(16'h308A, 2, 1);
    axi_read(fa(10), d, r);
    check(d, 32'h00, "incskip file");
    check(null_flag_o, 1'b0, "incskip flag");
    axi_write(fa(11), 32'h10, r);
    do_instr(16'h300B, 1, 1);
    check(acc_o, 8'h11, "incskip acc");
    // absolute jump with the top bits taken from latch bits 4:3
    for (int j = 0; j < 2; j++) begin
      axi_write(`OFS_STATUS, j, r);
      axi_write(`OFS_UTL, {25'h0, j_utl[j]}, r);
      do_instr({5'h08, j_imm[j]}, 2, 0);
      check(pc_o, j_pc[j], "jump pc");
      check(null_flag_o, j[0], "jump flag");
    end
    axi_read(`OFS_PC, d, r);
    check(d, {19'h0, j_pc[1]}, "pc read");
    close_out();
  end
endmodule
